//--- logic/iep_top.sv
// interrupt enable and priority registers with request gating and arbitration
`timescale 1ns/1ps
module iep_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// avalon-mm register port
	input wire logic [iep_pkg::IEP_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [iep_pkg::IEP_DATA_W-1:0] avs_writedata,
	input wire logic [iep_pkg::IEP_BE_W-1:0] avs_byteenable,
	output logic [iep_pkg::IEP_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// requests of sources enabled here, order bit 13 down to bit 1
	input wire logic [iep_pkg::IEP_NUM_GRP5-1:0] grp5_req,
	// requests of sources prioritised here, with their enables from elsewhere
	input wire logic [iep_pkg::IEP_NUM_PRIO-1:0] prio_src_req,
	input wire logic [iep_pkg::IEP_NUM_PRIO-1:0] prio_src_enable,
	// cpu acceptance
	output logic cpu_irq_valid,
	output logic [iep_pkg::IEP_PRIO_W-1:0] cpu_irq_level,
	output logic [iep_pkg::IEP_SRC_W-1:0] cpu_irq_source,
	input wire logic cpu_irq_ack,
	// summary interrupt
	output logic irq
);
	import iep_pkg::*;

	// ==========================================================
	// bus front end
	iep_bus_if bus ();

	iep_avalon_slave u_slave (
		.sys_clk(sys_clk),
		.rst(rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.bus(bus.slave)
	);

	// ==========================================================
	// storage
	logic [IEP_REG_W-1:0] interrupt_enable_group5;
	logic [IEP_REG_W-1:0] prio_regs [IEP_NUM_PREGS];
	logic [IEP_DATA_W-1:0] status;
	logic [IEP_DATA_W-1:0] mask;

	// ==========================================================
	// address decode
	wire hit_enable5 = (bus.addr == IEP_OFS_ENABLE5);
	wire hit_status = (bus.addr == IEP_OFS_STATUS);
	wire hit_mask = (bus.addr == IEP_OFS_MASK);
	wire hit_cpu = (bus.addr == IEP_OFS_CPU);
	logic [IEP_NUM_PREGS-1:0] hit_prio;
	assign hit_prio[0] = (bus.addr == IEP_OFS_PRIO0);
	assign hit_prio[1] = (bus.addr == IEP_OFS_PRIO1);
	assign hit_prio[2] = (bus.addr == IEP_OFS_PRIO2);
	assign hit_prio[3] = (bus.addr == IEP_OFS_PRIO3);

	// write data after byte lanes, against the current value of the addressed word; status ones are merged against zero
	wire [IEP_DATA_W-1:0] wr_enable5 =
		iep_merge_be({16'h0000, interrupt_enable_group5}, bus.wdata, bus.be);
	wire [IEP_DATA_W-1:0] wr_mask = iep_merge_be(mask, bus.wdata, bus.be);
	wire [IEP_DATA_W-1:0] wr_status_ones = iep_merge_be(IEP_ZERO, bus.wdata, bus.be);

	// ==========================================================
	// enable register
	wire [IEP_REG_W-1:0] next_enable5 = wr_enable5[IEP_REG_W-1:0] & IEP_ENABLE5_BITS;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			interrupt_enable_group5 <= IEP_ENABLE5_RESET;
		end else if (bus.wr_stb && hit_enable5) begin
			interrupt_enable_group5 <= next_enable5;
		end
	end

	// ==========================================================
	// priority registers, only field bits are kept
	genvar g;
	generate
		for (g = 0; g < IEP_NUM_PREGS; g++) begin : g_prio
			wire [IEP_DATA_W-1:0] wr_prio =
				iep_merge_be({16'h0000, prio_regs[g]}, bus.wdata, bus.be);
			wire [IEP_REG_W-1:0] next_prio = wr_prio[IEP_REG_W-1:0] & IEP_PRIO_BITS[g];
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					prio_regs[g] <= IEP_PRIO_RESET[g];
				end else if (bus.wr_stb && hit_prio[g]) begin
					prio_regs[g] <= next_prio;
				end
			end
		end
	endgenerate

	// ==========================================================
	// named enable bits
	wire capture9_irq_enable = interrupt_enable_group5[IEP_GRP5_BIT[0]];
	wire compare9_irq_enable = interrupt_enable_group5[IEP_GRP5_BIT[1]];
	wire serial_port3_event_enable = interrupt_enable_group5[IEP_GRP5_BIT[2]];
	wire serial_port3_fault_enable = interrupt_enable_group5[IEP_GRP5_BIT[3]];
	wire uart_four_tx_enable = interrupt_enable_group5[IEP_GRP5_BIT[4]];
	wire uart_four_rx_enable = interrupt_enable_group5[IEP_GRP5_BIT[5]];
	wire uart_four_error_enable = interrupt_enable_group5[IEP_GRP5_BIT[6]];
	wire i2c_three_master_enable = interrupt_enable_group5[IEP_GRP5_BIT[7]];
	wire i2c_three_slave_enable = interrupt_enable_group5[IEP_GRP5_BIT[8]];
	wire uart_three_tx_enable = interrupt_enable_group5[IEP_GRP5_BIT[9]];
	wire uart_three_rx_enable = interrupt_enable_group5[IEP_GRP5_BIT[10]];
	wire uart_three_error_enable = interrupt_enable_group5[IEP_GRP5_BIT[11]];

	wire [IEP_NUM_GRP5-1:0] grp5_enable = {
		uart_three_error_enable, uart_three_rx_enable, uart_three_tx_enable,
		i2c_three_slave_enable, i2c_three_master_enable, uart_four_error_enable,
		uart_four_rx_enable, uart_four_tx_enable, serial_port3_fault_enable,
		serial_port3_event_enable, compare9_irq_enable, capture9_irq_enable};

	// ==========================================================
	// named priority fields
	wire [IEP_PRIO_W-1:0] timer_one_priority = prio_regs[0][IEP_PSRC_LSB[0] +: IEP_PRIO_W];
	wire [IEP_PRIO_W-1:0] compare_one_priority = prio_regs[0][IEP_PSRC_LSB[1] +: IEP_PRIO_W];
	wire [IEP_PRIO_W-1:0] capture_one_priority = prio_regs[0][IEP_PSRC_LSB[2] +: IEP_PRIO_W];
	wire [IEP_PRIO_W-1:0] external_irq0_priority =
		prio_regs[0][IEP_PSRC_LSB[3] +: IEP_PRIO_W];
	wire [IEP_PRIO_W-1:0] timer_two_priority = prio_regs[1][IEP_PSRC_LSB[4] +: IEP_PRIO_W];
	wire [IEP_PRIO_W-1:0] compare_two_priority = prio_regs[1][IEP_PSRC_LSB[5] +: IEP_PRIO_W];
	wire [IEP_PRIO_W-1:0] capture_two_priority = prio_regs[1][IEP_PSRC_LSB[6] +: IEP_PRIO_W];
	wire [IEP_PRIO_W-1:0] uart_one_rx_priority = prio_regs[2][IEP_PSRC_LSB[7] +: IEP_PRIO_W];
	wire [IEP_PRIO_W-1:0] serial_port1_event_priority =
		prio_regs[2][IEP_PSRC_LSB[8] +: IEP_PRIO_W];
	wire [IEP_PRIO_W-1:0] serial_port1_fault_priority =
		prio_regs[2][IEP_PSRC_LSB[9] +: IEP_PRIO_W];
	wire [IEP_PRIO_W-1:0] timer_three_priority = prio_regs[2][IEP_PSRC_LSB[10] +: IEP_PRIO_W];
	wire [IEP_PRIO_W-1:0] adc_done_priority = prio_regs[3][IEP_PSRC_LSB[11] +: IEP_PRIO_W];
	wire [IEP_PRIO_W-1:0] uart_one_tx_priority = prio_regs[3][IEP_PSRC_LSB[12] +: IEP_PRIO_W];

	// ==========================================================
	// per-source level and effective request
	logic [IEP_PRIO_W-1:0] src_level [IEP_NUM_SRC];
	logic [IEP_NUM_SRC-1:0] src_live;

	// the field code is the level itself: 111 is seven, 001 is one
	always_comb begin
		for (int i = 0; i < IEP_NUM_SRC; i++) begin
			src_level[i] = IEP_GRP5_LEVEL;
		end
		src_level[12] = timer_one_priority;
		src_level[13] = compare_one_priority;
		src_level[14] = capture_one_priority;
		src_level[15] = external_irq0_priority;
		src_level[16] = timer_two_priority;
		src_level[17] = compare_two_priority;
		src_level[18] = capture_two_priority;
		src_level[19] = uart_one_rx_priority;
		src_level[20] = serial_port1_event_priority;
		src_level[21] = serial_port1_fault_priority;
		src_level[22] = timer_three_priority;
		src_level[23] = adc_done_priority;
		src_level[24] = uart_one_tx_priority;
		src_level[25] = IEP_LEVEL_OFF;
		src_level[26] = IEP_LEVEL_OFF;
	end

	// two spare slots keep the vector aligned to the status layout; level zero keeps them dead
	generate
		for (g = 0; g < IEP_NUM_SRC; g++) begin : g_live
			if (g < IEP_NUM_GRP5) begin : g_grp5
				assign src_live[g] = grp5_req[g] && grp5_enable[g]
					&& (src_level[g] != IEP_LEVEL_OFF);
			end else if (g < IEP_NUM_GRP5 + IEP_NUM_PRIO) begin : g_pri
				assign src_live[g] = prio_src_req[g-IEP_NUM_GRP5]
					&& prio_src_enable[g-IEP_NUM_GRP5]
					&& (src_level[g] != IEP_LEVEL_OFF);
			end else begin : g_none
				assign src_live[g] = 1'b0;
			end
		end
	endgenerate

	// ==========================================================
	// sticky status, write one to clear, cpu ack clears its source
	logic [IEP_DATA_W-1:0] ack_clear;
	always_comb begin
		ack_clear = IEP_ZERO;
		if (cpu_irq_ack && cpu_irq_valid) begin
			ack_clear[cpu_irq_source] = 1'b1;
		end
	end

	wire [IEP_DATA_W-1:0] sw_clear = (bus.wr_stb && hit_status) ? wr_status_ones : IEP_ZERO;
	wire [IEP_DATA_W-1:0] set_bits = {{(IEP_DATA_W-IEP_NUM_SRC){1'b0}}, src_live};
	// a new request in the clearing cycle survives: set is applied after clear
	wire [IEP_DATA_W-1:0] next_status =
		((status & ~sw_clear & ~ack_clear) | set_bits) & IEP_SRC_BITS;
	wire [IEP_DATA_W-1:0] next_mask = wr_mask & IEP_SRC_BITS;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			status <= IEP_ZERO;
			mask <= IEP_ZERO;
		end else begin
			status <= next_status;
			if (bus.wr_stb && hit_mask) begin
				mask <= next_mask;
			end
		end
	end

	// ==========================================================
	// arbitration toward the cpu
	// a source whose enable or level was dropped after latching is no longer offered
	wire [IEP_NUM_SRC-1:0] pend_live;
	generate
		for (g = 0; g < IEP_NUM_SRC; g++) begin : g_pend
			assign pend_live[g] = status[g] && mask[g] && (src_level[g] != IEP_LEVEL_OFF)
				&& (g < IEP_NUM_GRP5 ? grp5_enable[g % IEP_NUM_GRP5]
				: prio_src_enable[(g + IEP_NUM_PRIO - IEP_NUM_GRP5) % IEP_NUM_PRIO]);
		end
	endgenerate

	logic win_valid;
	logic [IEP_SRC_W-1:0] win_src;
	logic [IEP_PRIO_W-1:0] win_level;

	iep_arbiter u_arb (
		.cand(pend_live),
		.level(src_level),
		.win_valid(win_valid),
		.win_src(win_src),
		.win_level(win_level)
	);

	// registered view; one cycle behind the pending set
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cpu_irq_valid <= 1'b0;
			cpu_irq_level <= IEP_LEVEL_OFF;
			cpu_irq_source <= '0;
		end else begin
			cpu_irq_valid <= win_valid;
			cpu_irq_level <= win_level;
			cpu_irq_source <= win_src;
		end
	end

	assign irq = |(status & mask);

	// ==========================================================
	// read mux, unmapped and unimplemented bits read zero
	wire [IEP_DATA_W-1:0] cpu_view = {15'h0000, cpu_irq_valid,
		5'h00, cpu_irq_level, 3'h0, cpu_irq_source};
	logic [IEP_DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = IEP_ZERO;
		if (hit_enable5) begin
			rd_mux = {16'h0000, interrupt_enable_group5 & IEP_ENABLE5_BITS};
		end
		for (int i = 0; i < IEP_NUM_PREGS; i++) begin
			if (hit_prio[i]) begin
				rd_mux = {16'h0000, prio_regs[i] & IEP_PRIO_BITS[i]};
			end
		end
		if (hit_status) begin
			rd_mux = status;
		end
		if (hit_mask) begin
			rd_mux = mask;
		end
		if (hit_cpu) begin
			rd_mux = cpu_view;
		end
	end
	assign bus.rdata = rd_mux;

endmodule : iep_top

//--- logic/iep_pkg.sv
// shared constants, register map and types of the interrupt enable and priority block
package iep_pkg;

	// ==========================================================
	// widths
	localparam int IEP_DATA_W = 32;
	localparam int IEP_ADDR_W = 6;
	localparam int IEP_BE_W = 4;
	localparam int IEP_REG_W = 16;
	localparam int IEP_PRIO_W = 3;
	localparam int IEP_NUM_GRP5 = 12;
	localparam int IEP_NUM_PRIO = 15;
	localparam int IEP_NUM_SRC = 27;
	localparam int IEP_SRC_W = 5;
	localparam int IEP_NUM_PREGS = 4;

	typedef logic [IEP_PRIO_W-1:0] iep_level_t;
	typedef logic [IEP_SRC_W-1:0] iep_src_t;

	// ==========================================================
	// register map, byte addresses
	localparam logic [IEP_ADDR_W-1:0] IEP_OFS_ENABLE5 = 6'h00;
	localparam logic [IEP_ADDR_W-1:0] IEP_OFS_PRIO0 = 6'h04;
	localparam logic [IEP_ADDR_W-1:0] IEP_OFS_PRIO1 = 6'h08;
	localparam logic [IEP_ADDR_W-1:0] IEP_OFS_PRIO2 = 6'h0c;
	localparam logic [IEP_ADDR_W-1:0] IEP_OFS_PRIO3 = 6'h10;
	localparam logic [IEP_ADDR_W-1:0] IEP_OFS_STATUS = 6'h14;
	localparam logic [IEP_ADDR_W-1:0] IEP_OFS_MASK = 6'h18;
	localparam logic [IEP_ADDR_W-1:0] IEP_OFS_CPU = 6'h1c;

	// ==========================================================
	// implemented bits and reset values
	localparam logic [IEP_REG_W-1:0] IEP_ENABLE5_BITS = 16'h3fbe;
	localparam logic [IEP_REG_W-1:0] IEP_ENABLE5_RESET = 16'h0000;
	localparam logic [IEP_REG_W-1:0] IEP_PRIO_BITS [IEP_NUM_PREGS] =
		'{16'h7777, 16'h7770, 16'h7777, 16'h0077};
	localparam logic [IEP_REG_W-1:0] IEP_PRIO_RESET [IEP_NUM_PREGS] =
		'{16'h4444, 16'h4440, 16'h4444, 16'h0044};
	localparam logic [IEP_DATA_W-1:0] IEP_SRC_BITS = 32'h07ff_ffff;
	localparam logic [IEP_DATA_W-1:0] IEP_ZERO = 32'h0000_0000;
	localparam iep_level_t IEP_LEVEL_OFF = 3'h0;
	localparam iep_level_t IEP_GRP5_LEVEL = 3'h4;

	// ==========================================================
	// field positions
	localparam int IEP_GRP5_BIT [IEP_NUM_GRP5] = '{13, 12, 11, 10, 9, 8, 7, 5, 4, 3, 2, 1};
	localparam int IEP_PSRC_REG [IEP_NUM_PRIO] =
		'{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3};
	localparam int IEP_PSRC_LSB [IEP_NUM_PRIO] =
		'{12, 8, 4, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0, 0, 0};
	localparam int IEP_CPU_LVL_LSB = 8;
	localparam int IEP_CPU_VLD_BIT = 16;

	typedef enum logic {IEP_BUS_IDLE, IEP_BUS_DONE} iep_bus_state_e;

	// byte-lane merge of a write into an old value
	function automatic logic [IEP_DATA_W-1:0] iep_merge_be(
		input logic [IEP_DATA_W-1:0] old_val,
		input logic [IEP_DATA_W-1:0] new_val,
		input logic [IEP_BE_W-1:0] be);
		logic [IEP_DATA_W-1:0] res;
		res = old_val;
		for (int i = 0; i < IEP_BE_W; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction : iep_merge_be

endpackage : iep_pkg

//--- logic/iep_bus_if.sv
// register access channel between the bus slave and the register file
`timescale 1ns/1ps
interface iep_bus_if;
	import iep_pkg::*;
	logic [IEP_ADDR_W-1:0] addr;
	logic [IEP_DATA_W-1:0] wdata;
	logic [IEP_BE_W-1:0] be;
	logic wr_stb;
	logic [IEP_DATA_W-1:0] rdata;

	modport slave (output addr, output wdata, output be, output wr_stb, input rdata);
	modport regs (input addr, input wdata, input be, input wr_stb, output rdata);
endinterface : iep_bus_if

//--- logic/iep_avalon_slave.sv
// avalon-mm slave front end with one wait state
`timescale 1ns/1ps
module iep_avalon_slave (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// avalon-mm
	input wire logic [iep_pkg::IEP_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [iep_pkg::IEP_DATA_W-1:0] avs_writedata,
	input wire logic [iep_pkg::IEP_BE_W-1:0] avs_byteenable,
	output logic [iep_pkg::IEP_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// register side
	iep_bus_if.slave bus
);
	import iep_pkg::*;

	// ==========================================================
	// handshake
	iep_bus_state_e state;
	iep_bus_state_e next_state;
	wire req_any = avs_read | avs_write;

	// one wait state gives the read mux a full cycle before data is flopped
	assign avs_waitrequest = req_any && (state == IEP_BUS_IDLE);
	assign next_state = (state == IEP_BUS_IDLE && req_any) ? IEP_BUS_DONE : IEP_BUS_IDLE;
	assign bus.addr = avs_address;
	assign bus.wdata = avs_writedata;
	assign bus.be = avs_byteenable;
	assign bus.wr_stb = avs_write && (state == IEP_BUS_DONE);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= IEP_BUS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= IEP_ZERO;
		end else if (avs_read && state == IEP_BUS_IDLE) begin
			avs_readdata <= bus.rdata;
		end
	end

endmodule : iep_avalon_slave

//--- logic/iep_arbiter.sv
// picks the pending source with the highest priority level
`timescale 1ns/1ps
module iep_arbiter (
	// candidates
	input wire logic [iep_pkg::IEP_NUM_SRC-1:0] cand,
	input wire logic [iep_pkg::IEP_PRIO_W-1:0] level [iep_pkg::IEP_NUM_SRC],
	// winner
	output logic win_valid,
	output logic [iep_pkg::IEP_SRC_W-1:0] win_src,
	output logic [iep_pkg::IEP_PRIO_W-1:0] win_level
);
	import iep_pkg::*;

	// ==========================================================
	// linear search, lowest index wins a tie
	always_comb begin
		win_valid = 1'b0;
		win_src = '0;
		win_level = IEP_LEVEL_OFF;
		for (int i = 0; i < IEP_NUM_SRC; i++) begin
			if (cand[i] && level[i] > win_level) begin
				win_valid = 1'b1;
				win_src = iep_src_t'(i);
				win_level = level[i];
			end
		end
	end

endmodule : iep_arbiter

//--- sim/iep_top_sva.sv
// assertions on the register port and the cpu side of the interrupt block
`timescale 1ns/1ps
module iep_top_sva (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register port
	input wire logic [iep_pkg::IEP_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [iep_pkg::IEP_DATA_W-1:0] avs_writedata,
	input wire logic [iep_pkg::IEP_BE_W-1:0] avs_byteenable,
	input wire logic [iep_pkg::IEP_DATA_W-1:0] avs_readdata,
	input wire logic avs_waitrequest,
	// cpu side
	input wire logic cpu_irq_valid,
	input wire logic [iep_pkg::IEP_PRIO_W-1:0] cpu_irq_level,
	input wire logic [iep_pkg::IEP_SRC_W-1:0] cpu_irq_source,
	input wire logic cpu_irq_ack,
	input wire logic irq
);
	import iep_pkg::*;
	// ==========================================================
	// shadow of the writable registers, sh_q lags by one edge
	logic [IEP_DATA_W-1:0] sh [8];
	logic [IEP_DATA_W-1:0] sh_q [8];
	logic [2:0] idx;
	logic hit;
	logic rd_acc;
	iep_level_t exp_lvl;
	assign idx = avs_address[4:2];
	assign hit = (avs_address[1:0] == 2'h0) && !avs_address[5];
	assign rd_acc = avs_read && !avs_waitrequest;
	function automatic logic [IEP_DATA_W-1:0] imp(input logic [2:0] i);
		case (i)
			3'h0: return {16'h0000, 16'h3fbe};
			3'h1, 3'h2, 3'h3, 3'h4: return {16'h0000, IEP_PRIO_BITS[i-3'h1]};
			3'h6: return IEP_SRC_BITS;
			default: return IEP_ZERO;
		endcase
	endfunction : imp
	function automatic iep_level_t lvl(input iep_src_t s);
		if (s < IEP_NUM_GRP5) begin
			return sh_q[0][IEP_GRP5_BIT[s]] ? IEP_GRP5_LEVEL : IEP_LEVEL_OFF;
		end
		if (s >= IEP_NUM_SRC) begin
			return IEP_LEVEL_OFF;
		end
		return sh_q[IEP_PSRC_REG[s-12]+1][IEP_PSRC_LSB[s-12] +: 3];
	endfunction : lvl
	always_comb begin
		exp_lvl = lvl(cpu_irq_source);
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 8; i++) begin
				sh[i] <= (i > 0 && i < 5) ? {16'h0000, IEP_PRIO_RESET[i-1]} : IEP_ZERO;
				sh_q[i] <= (i > 0 && i < 5) ? {16'h0000, IEP_PRIO_RESET[i-1]} : IEP_ZERO;
			end
		end else begin
			sh_q <= sh;
			if (avs_write && !avs_waitrequest && hit && imp(idx) != IEP_ZERO) begin
				for (int b = 0; b < 4; b++) begin
					if (avs_byteenable[b]) begin
						sh[idx][b*8 +: 8] <= avs_writedata[b*8 +: 8];
					end
				end
			end
		end
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	AST_WAIT_FIRST: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
		|-> avs_waitrequest) else $error("request answered in its first cycle");
	AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("more than one wait cycle");
	AST_RD_UNMAPPED: assert property (rd_acc && !hit |-> avs_readdata == IEP_ZERO)
		else $error("unmapped read not zero");
	AST_RD_SHADOW: assert property (rd_acc && hit && imp(idx) != IEP_ZERO
		|-> avs_readdata == (sh[idx] & imp(idx))) else $error("register readback wrong");
	AST_RD_RSV: assert property (rd_acc && hit && (idx == 3'h5 || idx == 3'h7)
		|-> (avs_readdata & ((idx == 3'h5) ? 32'hf800_0000 : 32'hfffe_f8e0)) == IEP_ZERO)
		else $error("reserved bits read nonzero");
	AST_CPU_LEVEL: assert property (cpu_irq_valid
		|-> cpu_irq_level == exp_lvl && exp_lvl != IEP_LEVEL_OFF) else $error("cpu level wrong");
	AST_IRQ_MASK: assert property ((sh[6] & IEP_SRC_BITS) == IEP_ZERO |-> !irq)
		else $error("irq with all sources masked");
	AST_CPU_NEEDS_IRQ: assert property (cpu_irq_valid |-> $past(irq))
		else $error("cpu request without pending unmasked source");
	COV_READ: cover property (rd_acc && hit);
	COV_ACK: cover property (cpu_irq_valid && cpu_irq_ack);
	COV_IRQ: cover property ($rose(irq));
endmodule : iep_top_sva
bind iep_top iep_top_sva u_sva (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .cpu_irq_valid(cpu_irq_valid),
	.cpu_irq_level(cpu_irq_level), .cpu_irq_source(cpu_irq_source),
	.cpu_irq_ack(cpu_irq_ack), .irq(irq));

//--- sim/iep_cpu_model.sv
// cpu side model that takes the presented interrupt after a chosen delay
`timescale 1ns/1ps
module iep_cpu_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// presented interrupt and bench control
	input wire logic cpu_irq_valid,
	input wire logic accept,
	input wire logic [1:0] gap,
	// acceptance
	output logic cpu_irq_ack
);
	logic [2:0] cnt;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt <= 3'h0;
			cpu_irq_ack <= 1'b0;
		end else if (cpu_irq_ack) begin
			// cpu view lags the clear by one edge, so hold off past it
			cpu_irq_ack <= 1'b0;
			cnt <= {1'b0, gap} + 3'h2;
		end else if (!accept || !cpu_irq_valid) begin
			cnt <= {1'b0, gap};
		end else if (cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
		end else begin
			cpu_irq_ack <= 1'b1;
		end
	end
endmodule : iep_cpu_model

//--- sim/tb_iep_top.sv
// self-checking bench of the interrupt enable and priority block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fails++; \
	$display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb_iep_top;
	import iep_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [IEP_ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [IEP_DATA_W-1:0] avs_writedata = '0;
	logic [IEP_BE_W-1:0] avs_byteenable = '1;
	logic [IEP_DATA_W-1:0] avs_readdata;
	logic avs_waitrequest;
	logic [IEP_NUM_GRP5-1:0] grp5_req = '0;
	logic [IEP_NUM_PRIO-1:0] prio_src_req = '0;
	logic [IEP_NUM_PRIO-1:0] prio_src_enable = '1;
	logic cpu_irq_valid;
	logic [IEP_PRIO_W-1:0] cpu_irq_level;
	logic [IEP_SRC_W-1:0] cpu_irq_source;
	logic cpu_irq_ack;
	logic irq;
	logic accept = 1'b0;
	logic [1:0] gap = 2'h0;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [31:0] q_rd [$];
	logic [7:0] q_cpu [$];
	logic [31:0] exp_rd;
	logic [7:0] exp_cpu;
	logic [31:0] rnd;
	logic [2:0] code;
	logic [15:0] prst [4] = '{16'h4444, 16'h4440, 16'h4444, 16'h0044};
	logic [15:0] pbits [5] = '{16'h3fbe, 16'h7777, 16'h7770, 16'h7777, 16'h0077};
	iep_top dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .grp5_req(grp5_req),
		.prio_src_req(prio_src_req), .prio_src_enable(prio_src_enable),
		.cpu_irq_valid(cpu_irq_valid), .cpu_irq_level(cpu_irq_level),
		.cpu_irq_source(cpu_irq_source), .cpu_irq_ack(cpu_irq_ack), .irq(irq));
	iep_cpu_model u_cpu (.sys_clk(sys_clk), .rst(rst), .cpu_irq_valid(cpu_irq_valid),
		.accept(accept), .gap(gap), .cpu_irq_ack(cpu_irq_ack));
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ==========================================================
	// helpers
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report
	task automatic bus(input logic wr, input logic [IEP_ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		// waitrequest is sampled at the rising edge that completes the transfer
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic rd(input logic [IEP_ADDR_W-1:0] a, input logic [31:0] e);
		q_rd.push_back(e);
		bus(1'b0, a, 32'($urandom));
	endtask : rd
	task automatic pulse(input logic [IEP_NUM_GRP5-1:0] g, input logic [IEP_NUM_PRIO-1:0] p);
		@(posedge sys_clk);
		grp5_req <= g;
		prio_src_req <= p;
		@(posedge sys_clk);
		grp5_req <= '0;
		prio_src_req <= '0;
	endtask : pulse
	// field places of the prioritised sources
	function automatic int preg(input int j);
		return (j < 4) ? 0 : (j < 7) ? 1 : (j < 11) ? 2 : 3;
	endfunction : preg
	function automatic int plsb(input int j);
		return (j < 4) ? 12 - 4*j : (j < 7) ? 28 - 4*j : (j < 11) ? 40 - 4*j : 48 - 4*j;
	endfunction : plsb
	// ==========================================================
	// monitor and timeout
	always @(negedge sys_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			exp_rd = q_rd.pop_front();
			`CHK("readdata", exp_rd, avs_readdata)
		end
		if (cpu_irq_ack === 1'b1) begin
			exp_cpu = q_cpu.pop_front();
			`CHK("cpu_winner", exp_cpu, {cpu_irq_level, cpu_irq_source})
		end
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			final_report();
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(61458));
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		rd(6'h00, 32'h0000_0000);
		for (int r = 0; r < 4; r++) rd(6'(4 + 4*r), {16'h0000, prst[r]});
		rd(6'h18, 32'h0000_0000);
		bus(1'b1, 6'h20, 32'($urandom));
		rd(6'h20, 32'h0000_0000);
		rd(6'h02, 32'h0000_0000);
		bus(1'b1, 6'h1c, 32'($urandom));
		rd(6'h1c, 32'h0000_0000);
		// random data; unimplemented bits must read zero
		for (int k = 0; k < 3; k++) begin
			for (int r = 0; r < 5; r++) begin
				rnd = $urandom;
				bus(1'b1, 6'(4*r), rnd);
				rd(6'(4*r), {16'h0000, rnd[15:0] & pbits[r]});
			end
		end
		for (int r = 0; r < 4; r++) bus(1'b1, 6'(4 + 4*r), 32'h0000_0000);
		// only lane 1 written, lane 0 keeps its zero
		avs_byteenable <= 4'h2;
		bus(1'b1, 6'h04, 32'hffff_ffff);
		avs_byteenable <= 4'hf;
		rd(6'h04, 32'h0000_7700);
		bus(1'b1, 6'h04, 32'h0000_0000);
		// one enable bit at a time, all requests raised
		for (int i = 0; i < 12; i++) begin
			bus(1'b1, 6'h00, 32'h0000_0001 << ((i < 7) ? 13 - i : 12 - i));
			pulse('1, '1);
			rd(6'h14, 32'h0000_0001 << i);
			bus(1'b1, 6'h14, IEP_SRC_BITS);
		end
		// each priority field alone, codes 1 to 7
		bus(1'b1, 6'h18, IEP_SRC_BITS);
		for (int j = 0; j < 13; j++) begin
			code = 3'((j % 7) + 1);
			prio_src_enable <= 15'($urandom) | (15'h0001 << j);
			bus(1'b1, 6'(4 + 4*preg(j)), 32'(code) << plsb(j));
			pulse('0, '1);
			rd(6'h14, 32'h0000_1000 << j);
			rd(6'h1c, 32'h0001_0000 | (32'(code) << 8) | 32'(12 + j));
			bus(1'b1, 6'(4 + 4*preg(j)), 32'h0000_0000);
			bus(1'b1, 6'h14, IEP_SRC_BITS);
		end
		// competing sources, masked first, then taken by the cpu model
		prio_src_enable <= '1;
		bus(1'b1, 6'h18, 32'h0000_0000);
		bus(1'b1, 6'h00, 32'h0000_3fbe);
		bus(1'b1, 6'h04, 32'h0000_1234);
		pulse(12'h800, 15'h000f);
		rd(6'h14, 32'h0000_f800);
		@(negedge sys_clk);
		`CHK("irq", 1'b0, irq)
		`CHK("cpu_irq_valid", 1'b0, cpu_irq_valid)
		q_cpu = '{8'h8b, 8'h8f, 8'h6e, 8'h4d, 8'h2c};
		bus(1'b1, 6'h18, IEP_SRC_BITS);
		@(negedge sys_clk);
		`CHK("irq", 1'b1, irq)
		gap <= 2'($urandom_range(3));
		accept <= 1'b1;
		for (int n = 0; n < 300 && q_cpu.size() != 0; n++) @(posedge sys_clk);
		`CHK("cpu_acks_left", 0, q_cpu.size())
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHK("irq", 1'b0, irq)
		rd(6'h14, 32'h0000_0000);
		// reset again in mid-run
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(6'h04, {16'h0000, prst[0]});
		rd(6'h00, 32'h0000_0000);
		final_report();
	end
endmodule : tb_iep_top
